// ### shared/tmi_pkg.sv
// Constants, address map and state encoding for the tag memory serial port.
// Assumes a single 200 MHz core clock and a 16-bit word organised memory.
package tmi_pkg;
   // Clock and serial bus timing.
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCL_STD_KHZ = 100;
   localparam int SCL_FAST_KHZ = 400;
   localparam int SCL_FAST_CYC = 1000000 / (SCL_FAST_KHZ * CLK_PERIOD_NS);
   // Programming time for one word, rounded up to whole cycles.
   localparam int WR_PROG_NS = 100;
   localparam int WR_PROG_CYC = (WR_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Device select address (arbitrary value).
   localparam logic [6:0] DEV_ADDR = 7'h50;

   // Bank codes, also bits [14:13] of the serial byte address.
   localparam logic [1:0] BANK_RSV = 2'h0;
   localparam logic [1:0] BANK_EPC = 2'h1;
   localparam logic [1:0] BANK_TID = 2'h2;
   localparam logic [1:0] BANK_USR = 2'h3;
   localparam logic [15:0] EPC_BASE = 16'h2000;
   localparam logic [15:0] TID_BASE = 16'h4000;
   localparam logic [15:0] USR_BASE = 16'h6000;

   // Bank capacities in bits.
   localparam int EPC_CODE_BITS = 160;
   localparam int TID_BITS = 96;
   localparam int USR_BITS = 3328;

   // Radio-side bit addresses inside the EPC bank; byte offset is bit address / 8.
   localparam logic [12:0] EPC_CODE_RF = 13'h0020;
   localparam logic [12:0] DL_RF = 13'h01f0;
   localparam logic [12:0] CFG_RF = 13'h0200;
   localparam logic [12:0] EPC_CODE_OFS = EPC_CODE_RF >> 3;
   localparam logic [12:0] EPC_END_OFS = EPC_CODE_OFS + 13'(EPC_CODE_BITS / 8);
   localparam logic [12:0] DL_OFS = DL_RF >> 3;
   localparam logic [12:0] CFG_OFS = CFG_RF >> 3;
   localparam logic [12:0] TID_END_OFS = 13'(TID_BITS / 8);
   localparam logic [12:0] USR_END_OFS = 13'(USR_BITS / 8);

   // Last byte of each bank, where the pointer jumps to the next bank.
   localparam logic [15:0] EPC_LAST = EPC_BASE + 16'(CFG_OFS) + 16'h0001;
   localparam logic [15:0] TID_LAST = TID_BASE + 16'(TID_END_OFS) - 16'h0001;
   localparam logic [15:0] USR_LAST = USR_BASE + 16'(USR_END_OFS) - 16'h0001;

   // Word storage indices.
   localparam int PC_IDX = 1;
   localparam int DL_IDX = int'(EPC_END_OFS) / 2;
   localparam int CFG_IDX = DL_IDX + 1;
   localparam int USR_IDX0 = CFG_IDX + 1;
   localparam int MEM_WORDS = USR_IDX0 + USR_BITS / 16;

   // Reset values.
   localparam logic [15:0] PC_RESET = 16'h3000;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // Identifier content (arbitrary value).
   localparam logic [95:0] TID_VALUE = 96'h0123_4567_89ab_cdef_0011_2233;

   // Serial framing.
   localparam logic [3:0] BC_ACK = 4'h8;
   localparam logic [3:0] BC_END = 4'h9;
   localparam logic [1:0] BLOCK_WORDS = 2'h2;

   // Write buffer shape.
   localparam int FIFO_W = 32;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV = 3'b001,
      ST_AHI = 3'b010,
      ST_ALO = 3'b011,
      ST_WDAT = 3'b100,
      ST_RDAT = 3'b101
   } tmi_state_t;
endpackage : tmi_pkg

// ### shared/tmi_stream_if.sv
// Valid/ready word stream between the port engine and the write buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tmi_stream_if #(parameter int W = 32);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : tmi_stream_if
`default_nettype wire

// ### core/tmi_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous pin input; the output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module tmi_sync3 #(parameter logic RST_VAL = 1'b1) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic d,
   output logic q
);
   logic s1_r, s2_r, s3_r, q_r;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) q_r <= s3_r;
      end
   end

   assign q = q_r;
endmodule : tmi_sync3
`default_nettype wire

// ### core/tmi_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; storage has no reset, only the pointers and the count do.
`timescale 1ns/1ps
`default_nettype none
module tmi_fifo #(parameter int W = 32, parameter int DEPTH = 16) (
   input wire logic clk,
   input wire logic rstn,
   tmi_stream_if.snk wr,
   tmi_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] buf_r [DEPTH];
   logic [AW-1:0] wp_r, rp_r;
   logic [AW:0] cnt_r;

   // Handshakes and honest full and empty.
   wire logic push = wr.valid & wr.ready;
   wire logic pop = rd.valid & rd.ready;
   assign wr.ready = cnt_r != (AW + 1)'(DEPTH);
   assign rd.valid = cnt_r != '0;
   assign rd.data = buf_r[rp_r];

   // Pointer and occupancy bookkeeping.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   // Storage write.
   always_ff @(posedge clk) begin
      if (push) buf_r[wp_r] <= wr.data;
   end
endmodule : tmi_fifo
`default_nettype wire

// ### core/tmi_i2c_port.sv
// Serial two-wire slave port into the tag memory, seen by the host as a serial EEPROM.
// Assumes SCL and SDA arrive asynchronously from pins and an external pull-up on SDA.
`timescale 1ns/1ps
`default_nettype none
module tmi_i2c_port
   import tmi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic [15:0] cfg_word,
   output logic prog_busy
);
   tmi_state_t st_r, st_nxt;
   logic [3:0] bc_r, bc_nxt;
   logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, hib_r, hib_nxt;
   logic [15:0] ptr_r, ptr_nxt;
   logic [1:0] wcnt_r, wcnt_nxt;
   logic bsel_r, bsel_nxt, rw_r, rw_nxt, ackq_r, ackq_nxt, oe_r, oe_nxt;
   logic push_r, push_nxt, dout_r, busy_r;
   logic [31:0] pdat_r, pdat_nxt;
   logic [7:0] prog_r, prog_nxt;
   logic [15:0] mem_r [MEM_WORDS];
   logic scl_s, sda_s, scl_d_r, sda_d_r;

   tmi_stream_if #(.W(FIFO_W)) fin ();
   tmi_stream_if #(.W(FIFO_W)) fout ();

   // Array word index of a byte address; EPC words from zero, user words from USR_IDX0.
   // Bank picked by address bits 14:13; the password bank maps nowhere.
   function automatic logic [8:0] map_idx(input logic [15:0] a);
      logic [12:0] o;
      logic [8:0] r;
      o = a[12:0];
      r = 9'h000;
      if (!a[15] && a[14:13] == BANK_EPC) begin
         if (o < EPC_END_OFS) r = {1'b1, 8'(o >> 1)};
         else if (o[12:1] == DL_OFS[12:1]) r = {1'b1, 8'(DL_IDX)};
         else if (o[12:1] == CFG_OFS[12:1]) r = {1'b1, 8'(CFG_IDX)};
      end else if (!a[15] && a[14:13] == BANK_USR && o < USR_END_OFS) begin
         r = {1'b1, 8'(USR_IDX0 + int'(o >> 1))};
      end
      return r;
   endfunction : map_idx

   // Linear step with a jump from each bank's last byte to the next bank.
   // Bank starts at their fixed byte addresses.
   function automatic logic [15:0] next_addr(input logic [15:0] a);
      logic [15:0] n;
      n = a + 16'h0001;
      if (a == EPC_LAST) n = TID_BASE;
      else if (a == TID_LAST) n = USR_BASE;
      else if (a == USR_LAST) n = EPC_BASE;
      return n;
   endfunction : next_addr

   // Pins are resampled at 200 MHz, far above the 400 kHz bus clock.
   tmi_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
      .clk(core_clk),
      .rstn(rstn),
      .d(scl_i),
      .q(scl_s)
   );
   tmi_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
      .clk(core_clk),
      .rstn(rstn),
      .d(sda_i),
      .q(sda_s)
   );

   // Write words wait here while the array is busy programming.
   tmi_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wbuf (
      .clk(core_clk),
      .rstn(rstn),
      .wr(fin),
      .rd(fout)
   );

   // Bus events from the filtered pin levels.
   wire logic scl_rise = scl_s & ~scl_d_r;
   wire logic scl_fall = ~scl_s & scl_d_r;
   wire logic start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire logic stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // Read path: array word, fixed identifier, or zero where nothing is mapped.
   wire logic [8:0] pmap = map_idx(ptr_r);
   wire logic [15:0] rd_word = mem_r[pmap[7:0]];
   wire logic tid_hit = !ptr_r[15] && ptr_r[14:13] == BANK_TID && ptr_r[12:0] < TID_END_OFS;
   wire logic [7:0] tid_byte = 8'(TID_VALUE >> (8 * (11 - int'(ptr_r[3:0]))));
   wire logic [7:0] rd_byte = pmap[8] ? (ptr_r[0] ? rd_word[7:0] : rd_word[15:8]) :
      tid_hit ? tid_byte : 8'h00;

   // Only even, writable addresses take data.
   // At most two words per write; the buffer must have room.
   // Anything else is refused by leaving the data byte unacknowledged.
   wire logic wr_ok = !ptr_r[0] && pmap[8] && wcnt_r < BLOCK_WORDS && (!bsel_r || fin.ready);
   // Select byte matches only the fixed device address.
   wire logic dev_hit = sh_r[7:1] == DEV_ADDR;
   wire logic ack_ok = (st_r == ST_DEV) ? dev_hit : (st_r == ST_WDAT) ? wr_ok : 1'b1;

   // Byte-level engine. Nine clocks per byte: eight data bits, then the ack slot.
   always_comb begin
      st_nxt = st_r;
      bc_nxt = bc_r;
      sh_nxt = sh_r;
      tx_nxt = tx_r;
      ptr_nxt = ptr_r;
      hib_nxt = hib_r;
      bsel_nxt = bsel_r;
      wcnt_nxt = wcnt_r;
      rw_nxt = rw_r;
      ackq_nxt = ackq_r;
      oe_nxt = oe_r;
      push_nxt = 1'b0;
      pdat_nxt = pdat_r;
      if (stop_det) begin
         st_nxt = ST_IDLE;
         oe_nxt = 1'b0;
      end else if (start_det) begin
         st_nxt = ST_DEV;
         bc_nxt = 4'h0;
         oe_nxt = 1'b0;
         wcnt_nxt = 2'h0;
         bsel_nxt = 1'b0;
      end else if (st_r != ST_IDLE && scl_rise) begin
         if (bc_r < BC_ACK) begin
            sh_nxt = {sh_r[6:0], sda_s};
            bc_nxt = bc_r + 4'h1;
         end else if (st_r == ST_RDAT && sda_s) begin
            ackq_nxt = 1'b0;
         end
      end else if (st_r != ST_IDLE && scl_fall) begin
         if (bc_r == BC_ACK) begin
            bc_nxt = BC_END;
            ackq_nxt = ack_ok;
            oe_nxt = ack_ok && st_r != ST_RDAT;
            case (st_r)
               ST_DEV: rw_nxt = sh_r[0];
               ST_AHI: ptr_nxt[15:8] = sh_r;
               ST_ALO: ptr_nxt[7:0] = sh_r;
               ST_WDAT: begin
                  if (wr_ok && !bsel_r) begin
                     hib_nxt = sh_r;
                     bsel_nxt = 1'b1;
                  end else if (wr_ok) begin
                     push_nxt = 1'b1;
                     pdat_nxt = {ptr_r, hib_r, sh_r};
                     ptr_nxt = next_addr(next_addr(ptr_r));
                     wcnt_nxt = wcnt_r + 2'h1;
                     bsel_nxt = 1'b0;
                  end
               end
               // Sequential reads step the pointer after each byte.
               ST_RDAT: ptr_nxt = next_addr(ptr_r);
               default: ;
            endcase
         end else if (bc_r == BC_END) begin
            bc_nxt = 4'h0;
            oe_nxt = 1'b0;
            if (!ackq_r) begin
               st_nxt = ST_IDLE;
            end else begin
               case (st_r)
                  ST_DEV: begin
                     st_nxt = rw_r ? ST_RDAT : ST_AHI;
                     tx_nxt = rd_byte;
                     oe_nxt = rw_r && !rd_byte[7];
                  end
                  ST_AHI: st_nxt = ST_ALO;
                  ST_ALO: st_nxt = ST_WDAT;
                  ST_RDAT: begin
                     tx_nxt = rd_byte;
                     oe_nxt = !rd_byte[7];
                  end
                  default: ;
               endcase
            end
         end else if (st_r == ST_RDAT && bc_r != 4'h0) begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = !tx_r[6];
         end
      end
   end

   // Engine state.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r <= ST_IDLE;
         bc_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_r <= EPC_BASE;
         hib_r <= 8'h00;
         bsel_r <= 1'b0;
         wcnt_r <= 2'h0;
         rw_r <= 1'b0;
         ackq_r <= 1'b0;
         oe_r <= 1'b0;
         dout_r <= 1'b1;
         push_r <= 1'b0;
         pdat_r <= 32'h0000_0000;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         bc_r <= bc_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         ptr_r <= ptr_nxt;
         hib_r <= hib_nxt;
         bsel_r <= bsel_nxt;
         wcnt_r <= wcnt_nxt;
         rw_r <= rw_nxt;
         ackq_r <= ackq_nxt;
         oe_r <= oe_nxt;
         dout_r <= !oe_nxt;
         push_r <= push_nxt;
         pdat_r <= pdat_nxt;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // Drain side: one word per programming time; the stall is what fills the buffer.
   // A read of a word still waiting in the buffer returns the old value.
   wire logic drain = fout.valid & fout.ready;
   wire logic [8:0] dmap = map_idx(fout.data[31:16]);
   assign fout.ready = prog_r == 8'h00;
   assign fin.valid = push_r;
   assign fin.data = pdat_r;

   always_comb begin
      prog_nxt = prog_r;
      if (drain) prog_nxt = 8'(WR_PROG_CYC - 1);
      else if (prog_r != 8'h00) prog_nxt = prog_r - 8'h01;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         prog_r <= 8'h00;
         busy_r <= 1'b0;
      end else begin
         prog_r <= prog_nxt;
         busy_r <= prog_nxt != 8'h00;
      end
   end

   // Word array sized for EPC, download, configuration and user bytes.
   // The configuration word lives in the array and drives cfg_word.
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
         if (!rstn) begin
            mem_r[i] <= (i == PC_IDX) ? PC_RESET : (i == CFG_IDX) ? CFG_RESET : 16'h0000;
         end else if (drain && dmap[8] && dmap[7:0] == 8'(i)) begin
            mem_r[i] <= fout.data[15:0];
         end
      end
   end

   assign sda_o = dout_r;
   assign sda_oe = oe_r;
   assign cfg_word = mem_r[CFG_IDX];
   assign prog_busy = busy_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sda_stable_a: assert property ((scl_s && scl_d_r) |-> $stable(oe_r))
      else $error("SDA drive changed while SCL high");
   dev_ack_a: assert property ((st_r == ST_DEV && scl_fall && bc_r == BC_ACK && dev_hit)
      |=> oe_r ##0 st_r == ST_DEV)
      else $error("Matching select byte not acknowledged");
   ptr_step_a: assert property ((st_r == ST_RDAT && scl_fall && bc_r == BC_ACK &&
      ptr_r != EPC_LAST && ptr_r != TID_LAST && ptr_r != USR_LAST)
      |=> ptr_r == $past(ptr_r) + 16'h0001)
      else $error("Read pointer did not step by one");
   bank_wrap_a: assert property ((st_r == ST_RDAT && scl_fall && bc_r == BC_ACK &&
      ptr_r == EPC_LAST) |=> ptr_r == TID_BASE)
      else $error("Pointer did not jump to next bank");
   odd_nack_a: assert property ((st_r == ST_WDAT && scl_fall && bc_r == BC_ACK && ptr_r[0])
      |=> !oe_r && !push_r)
      else $error("Odd-address write acknowledged");
   block_len_a: assert property ((st_r == ST_WDAT && scl_fall && bc_r == BC_ACK &&
      wcnt_r == BLOCK_WORDS) |=> !oe_r ##1 !push_r)
      else $error("Third write word accepted");
   rsvd_hidden_a: assert property (push_r |-> pdat_r[31:29] != 3'h0)
      else $error("Write aimed at password bank");
   tid_ro_a: assert property (push_r |-> pdat_r[30:29] != BANK_TID)
      else $error("Identifier bank written");
   cfg_word_a: assert property ((drain && fout.data[31:16] == EPC_BASE + 16'(CFG_OFS))
      |=> cfg_word == $past(fout.data[15:0]) && prog_busy)
      else $error("Configuration word not updated");
endmodule : tmi_i2c_port
`default_nettype wire

// ### tb/tmi_i2c_master.sv
// Behavioural two-wire bus master: drives the bus clock and pulls the data line low.
// Assumes the bench resolves the open-drain data line with a pull-up to high.
`timescale 1ns/1ps
`default_nettype none
module tmi_i2c_master
   import tmi_pkg::*;
(
   input wire logic core_clk,
   input wire logic sda,
   output logic scl,
   output logic pull
);
   // fast mode limit
   // One bit spans SCL_FAST_CYC core cycles, so the bus never runs above 400 kHz.
   localparam int T_HIGH = SCL_FAST_CYC * 2 / 5;
   localparam int T_LOW = SCL_FAST_CYC - T_HIGH;
   localparam int T_SET = T_LOW / 3;
   logic scl_r = 1'b1;
   logic pull_r = 1'b0;

   // Pins follow the task state; changes land just after a clock edge.
   assign scl = scl_r;
   assign pull = pull_r;

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wait_cyc

   // data moves while clock low
   // Data changes well into the low phase, so the slave's hold time is never cut short.
   task automatic bit_io(input logic b, output logic s);
      wait_cyc(T_SET);
      pull_r = ~b;
      wait_cyc(T_LOW - T_SET);
      scl_r = 1'b1;
      wait_cyc(T_HIGH);
      s = sda;
      scl_r = 1'b0;
   endtask : bit_io

   task automatic start_cond();
      if (scl_r === 1'b0) begin
         wait_cyc(T_SET);
         pull_r = 1'b0;
         wait_cyc(T_LOW - T_SET);
         scl_r = 1'b1;
      end
      wait_cyc(T_HIGH / 2);
      pull_r = 1'b1;
      wait_cyc(T_HIGH / 2);
      scl_r = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      wait_cyc(T_SET);
      pull_r = 1'b1;
      wait_cyc(T_LOW - T_SET);
      scl_r = 1'b1;
      wait_cyc(T_HIGH / 2);
      pull_r = 1'b0;
      wait_cyc(T_HIGH / 2);
   endtask : stop_cond

   // Sends a byte, most significant bit first, and reports whether the slave acknowledged.
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : send

   // Receives a byte; the last byte of a read is answered with a release (no acknowledge).
   task automatic recv(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(last, s);
   endtask : recv
endmodule : tmi_i2c_master
`default_nettype wire

// ### tb/tag_memory_i2c_port_bench.sv
// Self-checking bench for the tag memory serial port, driven through a bus master model.
// Assumes tmi_pkg and the master model are compiled first; the data line has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tag_memory_i2c_port_bench
   import tmi_pkg::*;
;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic m_scl;
   logic m_pull;
   logic sda_w;
   logic sda_o;
   logic sda_oe;
   logic prog_busy;
   logic [15:0] cfg_word;
   logic ack;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   // The identifier's last byte is taken as the low byte of the arbitrary identifier value.
   logic [7:0] exp_rd [5] = '{TID_VALUE[7:0], 8'h12, 8'h34, 8'h56, 8'h78};

   // Open-drain data line: low whenever either party pulls it.
   assign sda_w = ~(sda_oe | m_pull);

   always #2.5 core_clk = ~core_clk;

   tmi_i2c_port i_tmi_i2c_port (
      .core_clk(core_clk),
      .rstn(rstn),
      .scl_i(m_scl),
      .sda_i(sda_w),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .cfg_word(cfg_word),
      .prog_busy(prog_busy)
   );

   tmi_i2c_master i_tmi_i2c_master (
      .core_clk(core_clk),
      .sda(sda_w),
      .scl(m_scl),
      .pull(m_pull)
   );

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   // Sends one byte and compares the slave's answer in the acknowledge slot.
   task automatic send_exp(input logic [7:0] d, input logic exp_ack, input string name);
      i_tmi_i2c_master.send(d, ack);
      check(name, {15'h0000, ack}, {15'h0000, exp_ack});
   endtask : send_exp

   // Start, write select and both address bytes; address bytes are always acknowledged.
   task automatic addr_phase(input logic [15:0] a);
      i_tmi_i2c_master.start_cond();
      send_exp(8'ha0, 1'b1, "select ack");
      send_exp(a[15:8], 1'b1, "addr hi ack");
      send_exp(a[7:0], 1'b1, "addr lo ack");
   endtask : addr_phase

   // Programming lasts a few tens of cycles, so a short bounded wait is ample.
   task automatic wait_idle();
      int n;
      n = 0;
      while (prog_busy !== 1'b0 && n < 2000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 2000) begin
         n_fail++;
         final_report();
      end
   endtask : wait_idle

   // Cuts a hung run short; the full sequence needs roughly 121000 cycles.
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 300000) begin
         n_fail = n_fail + 1;
         final_report();
      end
   end

   initial begin
      logic [7:0] rd;
      repeat (10) @(posedge core_clk);
      #1 rstn = 1'b1;
      repeat (10) @(posedge core_clk);
      #1;
      check("cfg reset", cfg_word, CFG_RESET);
      check("busy reset", {15'h0000, prog_busy}, 16'h0000);
      i_tmi_i2c_master.start_cond();
      send_exp(8'ha2, 1'b0, "foreign select");
      i_tmi_i2c_master.stop_cond();
      // block write of two words at the start of user memory
      addr_phase(16'h6000);
      send_exp(8'h12, 1'b1, "w0 hi");
      send_exp(8'h34, 1'b1, "w0 lo");
      send_exp(8'h56, 1'b1, "w1 hi");
      send_exp(8'h78, 1'b1, "w1 lo");
      i_tmi_i2c_master.stop_cond();
      wait_idle();
      addr_phase(16'h2040);
      send_exp(8'ha5, 1'b1, "cfg hi");
      send_exp(8'h5a, 1'b1, "cfg lo");
      i_tmi_i2c_master.stop_cond();
      wait_idle();
      check("cfg word", cfg_word, 16'ha55a);
      addr_phase(16'h6001);
      send_exp(8'hff, 1'b0, "odd data");
      i_tmi_i2c_master.stop_cond();
      // read across the identifier end into user memory
      addr_phase(16'h400b);
      i_tmi_i2c_master.start_cond();
      send_exp(8'ha1, 1'b1, "read select");
      for (int i = 0; i < 5; i++) begin
         i_tmi_i2c_master.recv(i == 4, rd);
         check("seq read", {8'h00, rd}, {8'h00, exp_rd[i]});
      end
      i_tmi_i2c_master.stop_cond();
      final_report();
   end
endmodule : tag_memory_i2c_port_bench
`default_nettype wire
